// ===== pcw_defines.svh
// What this block does
// - A host cycle through a disabled window is never acknowledged.
// - Reset clears the window enable register to 00h; all windows start off.
// - Enable bit 7 is read-write, turns I/O window 1 on; resets 0.
// - Enable bit 6 is read-write, turns I/O window 0 on; resets 0.
// - Enable bit 5 is reserved, read-only, and always reads 0.
// - Enable bits 4..0 are read-write, turn memory windows 4..0 on; reset 0.
// - Control bit 7 adds one ISA wait state to wide window 1 I/O cycles.
// - Control bit 3 adds one ISA wait state to wide window 0 I/O cycles.
// - Control bit 6 cuts narrow window 1 I/O cycles to three ISA cycles.
// - Control bit 2 cuts narrow window 0 I/O cycles to three ISA cycles.
// - Control bit 5 takes window 1 width from the card IOIS16 signal.
// - Control bit 1 takes window 0 width from the card IOIS16 signal.
// - Control bit 4 picks window 1 width: 0 narrow, 1 wide; ignored when auto.
// - Control bit 0 picks window 0 width: 0 narrow, 1 wide; ignored when auto.
// - Each socket has own copies; I/O control at 807h, local 07h and 47h.
// - Window enable at 806h, local 06 and 46; control register resets to 00h.
`ifndef PCW_DEFINES_SVH
`define PCW_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define PCW_SOCK_SPACE_WIN_EN 12'h806
`define PCW_SOCK_SPACE_IO_CTL 12'h807
`define PCW_OFS_WIN_EN 6'h06
`define PCW_OFS_IO_CTL 6'h07
`define PCW_SOCK_SEL_BIT 6
`define PCW_RST_VAL 8'h00
`define PCW_WIN_EN_WMASK 8'hDF

// ****************************************
// Field positions
// ****************************************
`define PCW_IO_ON_BASE 6
`define PCW_RSVD_BIT 5
`define PCW_NUM_MEM_WIN 5
`define PCW_IO_CTL_STRIDE 4
`define PCW_FIXED_OFS 0
`define PCW_AUTO_OFS 1
`define PCW_SHORTEN_OFS 2
`define PCW_EXTEND_OFS 3

// ****************************************
// Timing
// ****************************************
`define PCW_CLK_PERIOD_NS 20
`define PCW_ISA_CYCLE_NS 125
`define PCW_ISA_CLKS ((`PCW_ISA_CYCLE_NS + `PCW_CLK_PERIOD_NS - 1) / `PCW_CLK_PERIOD_NS)
`define PCW_STD8_ISA 6
`define PCW_STD16_ISA 3
`define PCW_ZWS8_ISA 3
`define PCW_WS_ISA 1

`endif

// ===== pcw_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module pcw_far_model
  import pcw_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Host side
  output logic cyc_req_o,
  output pcw_cyc_req_t cyc_info_o,
  input wire logic cyc_nak_i,
  input wire logic cyc_done_i,
  // Card side
  output logic [1:0] card_iois16_o
);
  // ****
  // Host master and card
  // ****
  initial begin
    cyc_req_o = 1'b0;
    cyc_info_o = '0;
    card_iois16_o = 2'b00;
  end
  // One cycle; clocks from take to done, -1 when refused, 0 on hang
  task automatic run(input pcw_cyc_req_t ci, output int n);
    @(negedge clk_i);
    cyc_req_o = 1'b1;
    cyc_info_o = ci;
    @(negedge clk_i);
    cyc_req_o = 1'b0;
    cyc_info_o = ~ci;
    n = 0;
    // Refusal pulse stands only in the cycle right after the take edge
    if (cyc_nak_i) n = -1;
    for (int k = 1; k < 60 && n == 0; k++) begin
      @(negedge clk_i);
      if (cyc_nak_i) n = -1;
      else if (cyc_done_i) n = k;
    end
  endtask : run
  // Card width signal level for both sockets
  task automatic set_width(input logic [1:0] v);
    card_iois16_o = v;
  endtask : set_width
endmodule : pcw_far_model
`default_nettype wire

// ===== pcw_pkg.sv
package pcw_pkg;

  // Per-socket register pair
  typedef struct packed {
    logic [7:0] win_en;
    logic [7:0] io_ctl;
  } pcw_sock_regs_t;

  // Host cycle request after address decode
  typedef struct packed {
    logic       sock;
    logic       is_io;
    logic [2:0] win;
  } pcw_cyc_req_t;

  // Cycle sequencer states
  typedef enum logic [1:0] {
    PCW_IDLE = 2'b01,
    PCW_RUN  = 2'b10
  } pcw_state_e;

endpackage : pcw_pkg

// ===== pcw_window_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcw_defines.svh"

module pcw_window_ctrl
  import pcw_pkg::*;
#(
  parameter int unsigned ISA_CLKS = `PCW_ISA_CLKS,
  parameter int unsigned CNT_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register access port, socket-local offset
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_hit_o,
  // Host cycle request
  input wire logic cyc_req_i,
  input wire pcw_cyc_req_t cyc_info_i,
  // Card width signal per socket
  input wire logic [1:0] card_iois16_i,
  // Cycle answer
  output logic cyc_ack_o,
  output logic cyc_nak_o,
  output logic cyc_busy_o,
  output logic cyc_wide_o,
  output logic cyc_done_o,
  // Register contents for the window decoders
  output pcw_sock_regs_t [1:0] sock_cfg_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pcw_sock_regs_t [1:0] regs;
    pcw_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [7:0] rdata;
    logic rvalid;
    logic hit;
    logic ack;
    logic nak;
    logic wide;
    logic done;
  } pcw_core_t;

  localparam logic [CNT_W-1:0] LEN_STD8 = CNT_W'(`PCW_STD8_ISA * ISA_CLKS);
  localparam logic [CNT_W-1:0] LEN_STD16 = CNT_W'(`PCW_STD16_ISA * ISA_CLKS);
  localparam logic [CNT_W-1:0] LEN_ZWS8 = CNT_W'(`PCW_ZWS8_ISA * ISA_CLKS);
  localparam logic [CNT_W-1:0] LEN_WS = CNT_W'(`PCW_WS_ISA * ISA_CLKS);

  pcw_core_t core_q;
  pcw_core_t core_d;

  // ****************************************
  // Helper functions
  // ****************************************

  // Picks one I/O window control field
  function automatic logic io_field(input logic [7:0] ctl, input logic w, input int unsigned ofs);
    int unsigned idx;
    idx = (w ? `PCW_IO_CTL_STRIDE : 0) + ofs;
    return ctl[idx];
  endfunction : io_field

  // Resolved data width of an I/O window
  function automatic logic io_wide(input logic [7:0] ctl, input logic w, input logic iois16);
    logic res;
    if (io_field(ctl, w, `PCW_AUTO_OFS)) begin
      res = iois16;
    end else begin
      res = io_field(ctl, w, `PCW_FIXED_OFS);
    end
    return res;
  endfunction : io_wide

  // Window enable check for one request
  function automatic logic win_on(input logic [7:0] en, input pcw_cyc_req_t rq);
    logic res;
    if (rq.is_io) begin
      res = (rq.win[2:1] == 2'b00) && en[`PCW_IO_ON_BASE + int'(rq.win[0])];
    end else begin
      res = (int'(rq.win) < `PCW_NUM_MEM_WIN) && en[rq.win];
    end
    return res;
  endfunction : win_on

  // Local offset decode shared by reads and writes
  function automatic logic [1:0] reg_sel(input logic [6:0] addr);
    logic [1:0] sel;
    sel[0] = (addr[5:0] == `PCW_OFS_WIN_EN);
    sel[1] = (addr[5:0] == `PCW_OFS_IO_CTL);
    return sel;
  endfunction : reg_sel

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic sock;
    logic [1:0] sel;
    logic [7:0] en;
    logic [7:0] ctl;
    logic w;
    logic wide;
    logic [CNT_W-1:0] len;
    sock = 1'b0;
    sel = 2'b00;
    en = 8'h00;
    ctl = 8'h00;
    w = 1'b0;
    wide = 1'b0;
    len = '0;
    core_d = core_q;
    core_d.rvalid = 1'b0;
    core_d.ack = 1'b0;
    core_d.nak = 1'b0;
    core_d.done = 1'b0;

    // Register write, one copy per socket
    sock = reg_addr_i[`PCW_SOCK_SEL_BIT];
    sel = reg_sel(reg_addr_i);
    if (reg_wr_i) begin
      if (sel[0]) begin
        core_d.regs[sock].win_en = reg_wdata_i & `PCW_WIN_EN_WMASK;
      end
      if (sel[1]) begin
        core_d.regs[sock].io_ctl = reg_wdata_i;
      end
    end

    // Register read, answered one cycle later
    if (reg_rd_i) begin
      core_d.rvalid = 1'b1;
      core_d.hit = |sel;
      unique case (1'b1)
        sel[0]: core_d.rdata = core_q.regs[sock].win_en & `PCW_WIN_EN_WMASK;
        sel[1]: core_d.rdata = core_q.regs[sock].io_ctl;
        default: core_d.rdata = 8'h00;
      endcase
    end

    // Cycle sequencer
    en = core_q.regs[cyc_info_i.sock].win_en;
    ctl = core_q.regs[cyc_info_i.sock].io_ctl;
    w = cyc_info_i.win[0];
    unique case (core_q.state)
      PCW_IDLE: begin
        if (cyc_req_i) begin
          if (!win_on(en, cyc_info_i)) begin
            core_d.nak = 1'b1;
          end else begin
            if (cyc_info_i.is_io) begin
              wide = io_wide(ctl, w, card_iois16_i[cyc_info_i.sock]);
              if (wide) begin
                len = LEN_STD16;
                if (io_field(ctl, w, `PCW_EXTEND_OFS)) begin
                  len = LEN_STD16 + LEN_WS;
                end
              end else begin
                len = LEN_STD8;
                if (io_field(ctl, w, `PCW_SHORTEN_OFS)) begin
                  len = LEN_ZWS8;
                end
              end
            end else begin
              wide = 1'b1;
              len = LEN_STD16;
            end
            core_d.ack = 1'b1;
            core_d.wide = wide;
            core_d.cnt = len - CNT_W'(1);
            core_d.state = PCW_RUN;
          end
        end
      end
      PCW_RUN: begin
        if (core_q.cnt == '0) begin
          core_d.done = 1'b1;
          core_d.state = PCW_IDLE;
        end else begin
          core_d.cnt = core_q.cnt - CNT_W'(1);
        end
      end
      default: begin
        core_d.state = PCW_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      core_q.regs[0].win_en <= `PCW_RST_VAL;
      core_q.regs[0].io_ctl <= `PCW_RST_VAL;
      core_q.regs[1].win_en <= `PCW_RST_VAL;
      core_q.regs[1].io_ctl <= `PCW_RST_VAL;
      core_q.state <= PCW_IDLE;
      core_q.cnt <= '0;
      core_q.rdata <= 8'h00;
      core_q.rvalid <= 1'b0;
      core_q.hit <= 1'b0;
      core_q.ack <= 1'b0;
      core_q.nak <= 1'b0;
      core_q.wide <= 1'b0;
      core_q.done <= 1'b0;
    end else begin
      core_q <= core_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o = core_q.rdata;
  assign reg_rvalid_o = core_q.rvalid;
  assign reg_hit_o = core_q.hit;
  assign cyc_ack_o = core_q.ack;
  assign cyc_nak_o = core_q.nak;
  assign cyc_busy_o = (core_q.state == PCW_RUN);
  assign cyc_wide_o = core_q.wide;
  assign cyc_done_o = core_q.done;
  assign sock_cfg_o = core_q.regs;

endmodule : pcw_window_ctrl
`default_nettype wire

// ===== pcw_window_ctrl_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pcw_window_ctrl_chk
  import pcw_pkg::*;
#(
  parameter int unsigned ISA_CLKS = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // Cycle port
  input wire logic cyc_req_i,
  input wire pcw_cyc_req_t cyc_info_i,
  input wire logic [1:0] card_iois16_i,
  input wire logic cyc_ack_o,
  input wire logic cyc_nak_o,
  input wire logic cyc_busy_o,
  input wire logic cyc_wide_o,
  input wire logic cyc_done_o,
  input wire pcw_sock_regs_t [1:0] sock_cfg_o
);
  // ****
  // Expected decode and cycle count
  // ****
  logic [7:0] ctl;
  logic [7:0] cnt_q;
  logic en;
  logic wd;
  pcw_sock_regs_t cf;
  assign cf = sock_cfg_o[cyc_info_i.sock];
  assign ctl = cf.io_ctl >> {cyc_info_i.win[0], 2'b00};
  assign wd = !cyc_info_i.is_io || (ctl[1] ? card_iois16_i[cyc_info_i.sock] : ctl[0]);
  assign en = cyc_info_i.is_io ? (cyc_info_i.win < 3'd2 && cf.win_en[6 + cyc_info_i.win[0]])
                               : (cyc_info_i.win < 3'd5 && cf.win_en[cyc_info_i.win]);
  // Counts clocks since the acknowledge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || cyc_ack_o) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence take_on_s;
    cyc_req_i && !cyc_busy_o && en;
  endsequence
  sequence take_off_s;
    cyc_req_i && !cyc_busy_o && !en;
  endsequence
  // Accepted cycle: answered, busy, width as resolved at the take edge
  property ack_on_p;
    take_on_s |=> cyc_ack_o && cyc_busy_o && cyc_wide_o == $past(wd);
  endproperty
  // Counter holds LEN-1 when done shows; LEN spans 3 to 6 ISA cycles
  property len_bound_p;
    cyc_done_o |-> cnt_q >= 3 * ISA_CLKS - 1 && cnt_q <= 6 * ISA_CLKS - 1;
  endproperty
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  rsvd_read_a: assert property (reg_rvalid_o && $past(reg_addr_i[5:0]) == 6'h06 |-> !reg_rdata_o[5])
    else $error("reserved bit read high");
  rsvd_store_a: assert property (!sock_cfg_o[0].win_en[5] && !sock_cfg_o[1].win_en[5])
    else $error("reserved bit stored");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst_i |=> sock_cfg_o == '0 && !cyc_busy_o)
    else $error("reset left state");
  nak_off_a: assert property (take_off_s |=> cyc_nak_o && !cyc_ack_o) else $error("disabled window acked");
  ack_on_a: assert property (ack_on_p) else $error("enabled cycle wrong");
  done_end_a: assert property (cyc_done_o |-> !cyc_busy_o && $past(cyc_busy_o)) else $error("done without busy");
  len_bound_a: assert property (len_bound_p) else $error("cycle length out of range");
endmodule : pcw_window_ctrl_chk
bind pcw_window_ctrl pcw_window_ctrl_chk #(.ISA_CLKS(ISA_CLKS)) u_pcw_window_ctrl_chk (.clk_i, .sys_rst_i,
  .reg_rd_i, .reg_addr_i, .reg_rdata_o, .reg_rvalid_o, .cyc_req_i, .cyc_info_i, .card_iois16_i,
  .cyc_ack_o, .cyc_nak_o, .cyc_busy_o, .cyc_wide_o, .cyc_done_o, .sock_cfg_o);
`default_nettype wire

// ===== tb_pcw.sv
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, e, s) total_checks++; if ((s) !== (e)) begin err_total++; $display("Error %s exp %0h got %0h", nm, e, s); end
module tb;
  import pcw_pkg::*;
  typedef struct {logic [6:0] a; logic [7:0] w; logic [7:0] r; logic h;} pcw_rrow_t;
  typedef struct {logic [7:0] c; logic io; pcw_cyc_req_t ci; int n;} pcw_crow_t;
  logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reg_hit_o, cyc_req_i, h;
  logic cyc_ack_o, cyc_nak_o, cyc_busy_o, cyc_wide_o, cyc_done_o;
  logic [6:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, d;
  logic [1:0] card_iois16_i;
  pcw_cyc_req_t cyc_info_i;
  pcw_sock_regs_t [1:0] sock_cfg_o;
  int err_total, total_checks, n;
  logic [6:0] ra[4] = '{7'h06, 7'h07, 7'h46, 7'h47};
  pcw_rrow_t rr[5] = '{'{7'h06, 8'hFF, 8'hDF, 1'b1}, '{7'h46, 8'h20, 8'h00, 1'b1}, '{7'h07, 8'hA5, 8'hA5, 1'b1},
    '{7'h47, 8'h5A, 8'h5A, 1'b1}, '{7'h10, 8'hFF, 8'h00, 1'b0}};
  pcw_crow_t cr[11] = '{'{8'h04, 1'b0, 5'h08, 3}, '{8'h04, 1'b0, 5'h09, 6}, '{8'h40, 1'b0, 5'h09, 3},
    '{8'h89, 1'b0, 5'h08, 4}, '{8'h89, 1'b0, 5'h09, 6}, '{8'h90, 1'b0, 5'h09, 4}, '{8'h32, 1'b0, 5'h09, 6},
    '{8'h32, 1'b1, 5'h08, 3}, '{8'h00, 1'b0, 5'h00, 3}, '{8'h00, 1'b0, 5'h01, -1}, '{8'h00, 1'b0, 5'h18, -1}};
  // ****
  // Design and far side
  // ****
  pcw_window_ctrl #(.ISA_CLKS(1)) u_pcw_window_ctrl (.clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .reg_hit_o, .cyc_req_i, .cyc_info_i, .card_iois16_i,
    .cyc_ack_o, .cyc_nak_o, .cyc_busy_o, .cyc_wide_o, .cyc_done_o, .sock_cfg_o);
  pcw_far_model u_pcw_far_model (.clk_i, .cyc_req_o(cyc_req_i), .cyc_info_o(cyc_info_i), .cyc_nak_i(cyc_nak_o),
    .cyc_done_i(cyc_done_o), .card_iois16_o(card_iois16_i));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    // Valid pulse stands only in this cycle
    d = reg_rdata_o;
    h = reg_hit_o;
    `CHECK("rvalid", 1'b1, reg_rvalid_o)
  endtask : rd
  task automatic conclude();
    $display("Checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    err_total = 0;
    total_checks = 0;
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    foreach (rr[i]) begin
      wr(rr[i].a, rr[i].w);
      rd(rr[i].a);
      `CHECK("reg", rr[i].r, d)
      `CHECK("hit", rr[i].h, h)
    end
    wr(7'h06, 8'hC1);
    foreach (cr[i]) begin
      wr(7'h07, cr[i].c);
      u_pcw_far_model.set_width({2{cr[i].io}});
      u_pcw_far_model.run(cr[i].ci, n);
      `CHECK("len", cr[i].n, n)
      if (n == 0) break;
    end
    rd(7'h06);
    `CHECK("sock_a", 8'hC1, d)
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHECK("rst", 8'h00, d)
    end
    conclude();
  end
endmodule : tb
`default_nettype wire
